// ---- design/vsm_core.sv ----
`timescale 1ns/1ps

// Overview of operation
// - first run bit at zero halts sequencer: refresh, memory access, syncs stopped.
// - sequencer runs only while both run bits are one.
// - second run bit falling clears the font bank select register.
// - video off forces black output and, unless 32-pixel shift is set, gives cpu full memory share.
// - video off leaves syncs, blanking and display enable running.
// - 32-pixel shift reloads every 4 char clocks, forces 2:7 interleave.
// - dot clock is master clock, or half of it when divide bit set.
// - otherwise reload every char clock, or every second with half-rate bit.
// - legacy interleave bit has no function and reads as zero.
// - character clock spans nine dots, or eight with cell-width bit set.
// - low write-mask bits enable cpu writes per plane.
// - odd/even and quad chain plane selects are anded with write mask.
// - text font fetches read plane 2 regardless of write mask.
// - attribute bit 3 high selects font from select bits 3,2,5.
// - attribute bit 3 low selects font from select bits 1,0,4.
// - font switching only when primary and secondary fonts differ.
// - font address is font number, character code, row.
// - font select changes take effect at next character row.
// - quad chain uses address bits 0 and 1 as plane select.
// - odd/even sends even addresses to planes 0,2 and odd to 1,3.
module vsm_core (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // indexed register port
    input  wire logic [2:0]  reg_index_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // cpu memory access
    input  wire logic        cpu_req_i,
    input  wire logic        cpu_we_i,
    input  wire logic [1:0]  cpu_addr_lo_i,
    input  wire logic [3:0]  read_map_i,
    input  wire logic        gfx_odd_even_i,
    output logic      [3:0]  plane_we_o,
    output logic      [3:0]  plane_re_o,
    // font fetch
    input  wire logic        row_start_i,
    input  wire logic        attr_bit3_i,
    input  wire logic [7:0]  char_code_i,
    input  wire logic [4:0]  char_row_i,
    output logic      [15:0] font_addr_o,
    output logic             font_plane2_re_o,
    // timing
    input  wire logic        hsync_i,
    input  wire logic        vsync_i,
    input  wire logic        display_enable_flag_i,
    input  wire logic        pixel_valid_i,
    output logic             running_o,
    output logic             refresh_en_o,
    output logic             mem_access_en_o,
    output logic             hsync_o,
    output logic             vsync_o,
    output logic             display_enable_flag_o,
    output logic             video_black_o,
    output logic             dot_clk_en_o,
    output logic             char_clk_o,
    output logic             serializer_load_o,
    output logic      [1:0]  interleave_o,
    output logic             extended_memory_o
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0]  halt_reg;
    logic [7:0]  clocking_mode_reg;
    logic [7:0]  plane_write_mask_reg;
    logic [7:0]  font_bank_select_reg;
    logic [7:0]  memory_addressing_mode_reg;
    logic        run;
    logic        run2_fall;
    logic        restart;
    logic        run_d_reg;

    assign run       = halt_reg[vsm_pkg::HALT_RUN1_BIT] && halt_reg[vsm_pkg::HALT_RUN2_BIT];
    assign run2_fall = reg_wr_i && (reg_index_i == vsm_pkg::IDX_HALT)
                       && halt_reg[vsm_pkg::HALT_RUN2_BIT]
                       && !reg_wdata_i[vsm_pkg::HALT_RUN2_BIT];

    // halt control register
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            halt_reg <= vsm_pkg::HALT_RST;
        end else if (ce_i && reg_wr_i && reg_index_i == vsm_pkg::IDX_HALT) begin
            halt_reg <= reg_wdata_i & vsm_pkg::HALT_MASK;
        end
    end

    // clocking mode; legacy bit never stored
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clocking_mode_reg <= vsm_pkg::CLOCKING_RST;
        end else if (ce_i && reg_wr_i && reg_index_i == vsm_pkg::IDX_CLOCKING) begin
            clocking_mode_reg <= reg_wdata_i & vsm_pkg::CLOCKING_MASK;
        end
    end

    // plane write mask
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            plane_write_mask_reg <= vsm_pkg::WMASK_RST;
        end else if (ce_i && reg_wr_i && reg_index_i == vsm_pkg::IDX_WMASK) begin
            plane_write_mask_reg <= reg_wdata_i & vsm_pkg::WMASK_MASK;
        end
    end

    // font bank select, cleared when second run bit falls
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            font_bank_select_reg <= vsm_pkg::FONT_RST;
        end else if (ce_i && run2_fall) begin
            font_bank_select_reg <= 8'h00;
        end else if (ce_i && reg_wr_i && reg_index_i == vsm_pkg::IDX_FONT) begin
            font_bank_select_reg <= reg_wdata_i & vsm_pkg::FONT_MASK;
        end
    end

    // memory addressing mode
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            memory_addressing_mode_reg <= vsm_pkg::MEMMODE_RST;
        end else if (ce_i && reg_wr_i && reg_index_i == vsm_pkg::IDX_MEMMODE) begin
            memory_addressing_mode_reg <= reg_wdata_i & vsm_pkg::MEMMODE_MASK;
        end
    end

    // registered read data
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            unique case (reg_index_i)
                vsm_pkg::IDX_HALT:     reg_rdata_o <= halt_reg;
                vsm_pkg::IDX_CLOCKING: reg_rdata_o <= clocking_mode_reg;
                vsm_pkg::IDX_WMASK:    reg_rdata_o <= plane_write_mask_reg;
                vsm_pkg::IDX_FONT:     reg_rdata_o <= font_bank_select_reg;
                vsm_pkg::IDX_MEMMODE:  reg_rdata_o <= memory_addressing_mode_reg;
                default:               reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // dot and character clock generation
    // ------------------------------------------------------------
    logic       div_phase_reg;
    logic       dot_tick;
    logic [3:0] dot_cnt_reg;
    logic [3:0] dots_per_char;
    logic       char_tick;
    logic [1:0] load_cnt_reg;
    logic [1:0] load_period;

    // remember run state to spot release from halt
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            run_d_reg <= 1'b0;
        end else if (ce_i) begin
            run_d_reg <= run;
        end
    end
    assign restart = run && !run_d_reg;

    // divide master clock by two when selected
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            div_phase_reg <= 1'b0;
        end else if (ce_i) begin
            if (!run || restart) begin
                div_phase_reg <= 1'b0;
            end else begin
                div_phase_reg <= !div_phase_reg;
            end
        end
    end
    assign dot_tick = run && (!clocking_mode_reg[vsm_pkg::CLK_DIV2_BIT] || div_phase_reg);

    assign dots_per_char = clocking_mode_reg[vsm_pkg::CLK_CELL8_BIT] ?
                           vsm_pkg::DOTS_EIGHT : vsm_pkg::DOTS_NINE;
    assign char_tick = dot_tick && (dot_cnt_reg == dots_per_char - 4'h1);

    // dots within a character cell
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dot_cnt_reg <= 4'h0;
        end else if (ce_i) begin
            if (!run || restart) begin
                dot_cnt_reg <= 4'h0;
            end else if (char_tick) begin
                dot_cnt_reg <= 4'h0;
            end else if (dot_tick) begin
                dot_cnt_reg <= dot_cnt_reg + 4'h1;
            end
        end
    end

    // serializer reload cadence
    always_comb begin
        if (clocking_mode_reg[vsm_pkg::CLK_SH32_BIT]) begin
            load_period = vsm_pkg::RELOAD_32;
        end else if (clocking_mode_reg[vsm_pkg::CLK_HALFLD_BIT]) begin
            load_period = vsm_pkg::RELOAD_16;
        end else begin
            load_period = vsm_pkg::RELOAD_8;
        end
    end

    // character clocks since last reload
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            load_cnt_reg <= 2'h0;
        end else if (ce_i) begin
            if (!run || restart) begin
                load_cnt_reg <= 2'h0;
            end else if (char_tick) begin
                load_cnt_reg <= (load_cnt_reg >= load_period) ? 2'h0 : load_cnt_reg + 2'h1;
            end
        end
    end

    // registered timing outputs
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dot_clk_en_o      <= 1'b0;
            char_clk_o        <= 1'b0;
            serializer_load_o <= 1'b0;
            interleave_o      <= 2'(vsm_pkg::VSM_IL_NORMAL);
        end else if (ce_i) begin
            dot_clk_en_o      <= dot_tick;
            char_clk_o        <= char_tick;
            serializer_load_o <= char_tick && (load_cnt_reg >= load_period);
            if (clocking_mode_reg[vsm_pkg::CLK_SH32_BIT]) begin
                interleave_o <= 2'(vsm_pkg::VSM_IL_2_7);
            end else if (clocking_mode_reg[vsm_pkg::CLK_VOFF_BIT]) begin
                interleave_o <= 2'(vsm_pkg::VSM_IL_CPU_FULL);
            end else begin
                interleave_o <= 2'(vsm_pkg::VSM_IL_NORMAL);
            end
        end
    end

    // ------------------------------------------------------------
    // halt gating, syncs and blanking
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            running_o             <= 1'b0;
            refresh_en_o          <= 1'b0;
            mem_access_en_o       <= 1'b0;
            hsync_o               <= 1'b0;
            vsync_o               <= 1'b0;
            display_enable_flag_o <= 1'b0;
            video_black_o         <= 1'b1;
            extended_memory_o     <= 1'b0;
        end else if (ce_i) begin
            running_o             <= run;
            refresh_en_o          <= run;
            mem_access_en_o       <= run;
            hsync_o               <= run && hsync_i;
            vsync_o               <= run && vsync_i;
            display_enable_flag_o <= run && display_enable_flag_i;
            video_black_o         <= clocking_mode_reg[vsm_pkg::CLK_VOFF_BIT]
                                     || !pixel_valid_i;
            extended_memory_o     <= memory_addressing_mode_reg[1];
        end
    end

    // ------------------------------------------------------------
    // plane selection for cpu accesses
    // ------------------------------------------------------------
    logic [3:0] addr_sel;
    logic       quad;
    logic       odd_even;

    assign quad     = memory_addressing_mode_reg[vsm_pkg::MEM_QUAD_BIT];
    assign odd_even = !memory_addressing_mode_reg[vsm_pkg::MEM_SEQ_BIT];

    // address-derived plane select
    always_comb begin
        if (quad) begin
            addr_sel = 4'h1 << cpu_addr_lo_i;
        end else if (odd_even) begin
            addr_sel = cpu_addr_lo_i[0] ? 4'hA : 4'h5;
        end else begin
            addr_sel = 4'hF;
        end
    end

    // registered plane enables
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            plane_we_o <= 4'h0;
            plane_re_o <= 4'h0;
        end else if (ce_i) begin
            if (run && cpu_req_i && cpu_we_i) begin
                plane_we_o <= addr_sel & plane_write_mask_reg[3:0];
            end else begin
                plane_we_o <= 4'h0;
            end
            if (run && cpu_req_i && !cpu_we_i) begin
                if (quad) begin
                    plane_re_o <= addr_sel;
                end else if (odd_even || gfx_odd_even_i) begin
                    plane_re_o <= read_map_i & (cpu_addr_lo_i[0] ? 4'hA : 4'h5);
                end else begin
                    plane_re_o <= read_map_i;
                end
            end else begin
                plane_re_o <= 4'h0;
            end
        end
    end

    // font fetch ignores write mask
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            font_plane2_re_o <= 1'b0;
        end else if (ce_i) begin
            font_plane2_re_o <= run && char_tick;
        end
    end

    vsm_font_addr u_font_addr (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .row_start_i (row_start_i),
        .font_sel_i  (font_bank_select_reg[5:0]),
        .attr_bit3_i (attr_bit3_i),
        .char_code_i (char_code_i),
        .char_row_i  (char_row_i),
        .font_addr_o (font_addr_o)
    );

endmodule

// ---- design/vsm_pkg.sv ----
package vsm_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_HALT     = 3'h0;
    localparam logic [2:0] IDX_CLOCKING = 3'h1;
    localparam logic [2:0] IDX_WMASK    = 3'h2;
    localparam logic [2:0] IDX_FONT     = 3'h3;
    localparam logic [2:0] IDX_MEMMODE  = 3'h4;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int HALT_RUN1_BIT  = 1;
    localparam int HALT_RUN2_BIT  = 0;
    localparam int CLK_CELL8_BIT  = 0;
    localparam int CLK_LEGACY_BIT = 1;
    localparam int CLK_HALFLD_BIT = 2;
    localparam int CLK_DIV2_BIT   = 3;
    localparam int CLK_SH32_BIT   = 4;
    localparam int CLK_VOFF_BIT   = 5;
    localparam int MEM_SEQ_BIT    = 2;
    localparam int MEM_QUAD_BIT   = 3;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] HALT_RST     = 8'h00;
    localparam logic [7:0] CLOCKING_RST = 8'h00;
    localparam logic [7:0] WMASK_RST    = 8'h00;
    localparam logic [7:0] FONT_RST     = 8'h00;
    localparam logic [7:0] MEMMODE_RST  = 8'h00;
    localparam logic [7:0] HALT_MASK     = 8'h03;
    localparam logic [7:0] CLOCKING_MASK = 8'h3D;
    localparam logic [7:0] WMASK_MASK    = 8'h0F;
    localparam logic [7:0] FONT_MASK     = 8'h3F;
    localparam logic [7:0] MEMMODE_MASK  = 8'h0E;

    // ------------------------------------------------------------
    // timing counts
    // ------------------------------------------------------------
    localparam logic [3:0] DOTS_NINE  = 4'h9;
    localparam logic [3:0] DOTS_EIGHT = 4'h8;
    localparam logic [1:0] RELOAD_32  = 2'h3; // reload every 4 char clocks
    localparam logic [1:0] RELOAD_16  = 2'h1;
    localparam logic [1:0] RELOAD_8   = 2'h0;

    typedef enum logic [1:0] {
        VSM_IL_NORMAL,
        VSM_IL_2_7,
        VSM_IL_CPU_FULL
    } vsm_interleave_e;

endpackage

// ---- design/vsm_font_addr.sv ----
`timescale 1ns/1ps

// font fetch address former for plane 2
module vsm_font_addr (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        row_start_i,
    input  wire logic [5:0]  font_sel_i,
    input  wire logic        attr_bit3_i,
    input  wire logic [7:0]  char_code_i,
    input  wire logic [4:0]  char_row_i,
    output logic      [15:0] font_addr_o
);

    logic [5:0] sel_row_reg;
    logic [2:0] primary;
    logic [2:0] secondary;
    logic [2:0] font_num;

    // latch selection only at row start
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sel_row_reg <= 6'h00;
        end else if (ce_i && row_start_i) begin
            sel_row_reg <= font_sel_i;
        end
    end

    // font numbers from select bits
    assign primary   = {sel_row_reg[1], sel_row_reg[0], sel_row_reg[4]};
    assign secondary = {sel_row_reg[3], sel_row_reg[2], sel_row_reg[5]};
    assign font_num  = (attr_bit3_i && (primary != secondary)) ? secondary : primary;

    // registered plane 2 address
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            font_addr_o <= 16'h0000;
        end else if (ce_i) begin
            font_addr_o <= {font_num, char_code_i, char_row_i};
        end
    end

endmodule

// ---- verification/vsm_chk.sv ----
`timescale 1ns/1ps

// port-level checker for the sequencer core
module vsm_chk (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    input wire logic [2:0]  reg_index_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        cpu_req_i,
    input wire logic        cpu_we_i,
    input wire logic [3:0]  plane_we_o,
    input wire logic [7:0]  char_code_i,
    input wire logic [4:0]  char_row_i,
    input wire logic [15:0] font_addr_o,
    input wire logic        hsync_i,
    input wire logic        vsync_i,
    input wire logic        display_enable_flag_i,
    input wire logic        running_o,
    input wire logic        refresh_en_o,
    input wire logic        mem_access_en_o,
    input wire logic        hsync_o,
    input wire logic        vsync_o,
    input wire logic        display_enable_flag_o,
    input wire logic        video_black_o,
    input wire logic        char_clk_o,
    input wire logic [1:0]  interleave_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    logic live_reg;

    // previous edge was out of reset with clock enable high
    always_ff @(posedge clock_i) begin
        live_reg <= rst_n_i & ce_i;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    run_flags_a: assert property (
        running_o == refresh_en_o && running_o == mem_access_en_o)
        else $error("refresh or memory access enable differs from run state");
    hsync_gate_a: assert property (
        live_reg |-> hsync_o == ($past(hsync_i) && running_o))
        else $error("horizontal sync not gated by run state");
    vsync_gate_a: assert property (
        live_reg |-> vsync_o == ($past(vsync_i) && running_o))
        else $error("vertical sync not gated by run state");
    de_gate_a: assert property (
        live_reg |-> display_enable_flag_o == ($past(display_enable_flag_i) && running_o))
        else $error("display enable not passed while running");
    legacy_zero_a: assert property (
        live_reg && $past(reg_index_i) == vsm_pkg::IDX_CLOCKING
        |-> reg_rdata_o[1] == 1'b0 && reg_rdata_o[7:6] == 2'h0)
        else $error("unused clocking mode bits read nonzero");
    video_off_a: assert property (
        interleave_o == 2'h2 |-> video_black_o)
        else $error("cpu full share without black video");
    char_gap_a: assert property (
        char_clk_o |=> !char_clk_o [*7])
        else $error("character clock shorter than eight dots");
    font_code_a: assert property (
        live_reg |-> font_addr_o[12:0] == {$past(char_code_i), $past(char_row_i)})
        else $error("font address code or row field wrong");
    plane_write_a: assert property (
        plane_we_o != 4'h0 |-> $past(cpu_req_i && cpu_we_i) && running_o)
        else $error("plane write without a cpu write while running");
endmodule

// ---- verification/vsm_timing_model.sv ----
`timescale 1ns/1ps

// scan timing source standing in for the display timing generator
module vsm_timing_model (
    input  wire logic clock_i,
    output logic      hsync_o,
    output logic      vsync_o,
    output logic      display_enable_flag_o,
    output logic      pixel_valid_o
);
    logic [7:0] count_reg = 8'h00;

    // scan position advances on the falling edge, off the core's sampling edge
    always @(negedge clock_i) begin
        count_reg <= count_reg + 8'h01;
    end

    // sync, enable and pixel levels all toggle so gating is visible
    assign hsync_o               = (count_reg[4:0] < 5'h04);
    assign vsync_o               = (count_reg[7:6] == 2'h3);
    assign display_enable_flag_o = ~count_reg[4];
    assign pixel_valid_o         = ~count_reg[4] & ~count_reg[7];
endmodule

// ---- verification/vsm_tb.sv ----
`timescale 1ns/1ps

module testbench;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [2:0]  reg_index_i = 3'h0;
    logic        reg_wr_i = 1'b0, gfx_odd_even_i = 1'b0, ce_i = 1'b1;
    logic [7:0]  reg_wdata_i = 8'h00, char_code_i = 8'h00;
    logic        cpu_req_i = 1'b0, cpu_we_i = 1'b0;
    logic [1:0]  cpu_addr_lo_i = 2'h0;
    logic [3:0]  read_map_i = 4'h0;
    logic        row_start_i = 1'b0, attr_bit3_i = 1'b0;
    logic [4:0]  char_row_i = 5'h00;
    logic        hsync_i, vsync_i, display_enable_flag_i, pixel_valid_i;
    logic [7:0]  reg_rdata_o;
    logic [3:0]  plane_we_o, plane_re_o;
    logic [15:0] font_addr_o;
    logic [1:0]  interleave_o;
    logic        font_plane2_re_o, running_o, refresh_en_o, mem_access_en_o, hsync_o;
    logic        vsync_o, display_enable_flag_o, video_black_o, dot_clk_en_o, char_clk_o;
    logic        serializer_load_o, extended_memory_o;
    int          fail_count = 0;
    int          checks = 0;

    always #10 clock_i = ~clock_i;

    vsm_core dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .reg_index_i(reg_index_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
        .cpu_addr_lo_i(cpu_addr_lo_i), .read_map_i(read_map_i),
        .gfx_odd_even_i(gfx_odd_even_i), .plane_we_o(plane_we_o), .plane_re_o(plane_re_o),
        .row_start_i(row_start_i), .attr_bit3_i(attr_bit3_i), .char_code_i(char_code_i),
        .char_row_i(char_row_i), .font_addr_o(font_addr_o),
        .font_plane2_re_o(font_plane2_re_o), .hsync_i(hsync_i), .vsync_i(vsync_i),
        .display_enable_flag_i(display_enable_flag_i), .pixel_valid_i(pixel_valid_i),
        .running_o(running_o), .refresh_en_o(refresh_en_o),
        .mem_access_en_o(mem_access_en_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
        .display_enable_flag_o(display_enable_flag_o), .video_black_o(video_black_o),
        .dot_clk_en_o(dot_clk_en_o), .char_clk_o(char_clk_o),
        .serializer_load_o(serializer_load_o), .interleave_o(interleave_o),
        .extended_memory_o(extended_memory_o));

    vsm_timing_model timing_u (.clock_i(clock_i), .hsync_o(hsync_i), .vsync_o(vsync_i),
        .display_enable_flag_o(display_enable_flag_i), .pixel_valid_o(pixel_valid_i));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] idx, input logic [7:0] d);
        @(negedge clock_i);
        reg_index_i = idx;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
        @(negedge clock_i);
        reg_index_i = idx;
        @(negedge clock_i);
        chk(16'(reg_rdata_o), 16'(exp));
    endtask

    // one cpu cycle; checks write or read plane enables
    task automatic acc(input logic we, input logic [1:0] a, input logic [3:0] m,
                       input logic [3:0] exp);
        @(negedge clock_i);
        cpu_req_i = 1'b1;
        cpu_we_i = we;
        cpu_addr_lo_i = a;
        read_map_i = m;
        @(negedge clock_i);
        cpu_req_i = 1'b0;
        chk(16'(we ? plane_we_o : plane_re_o), 16'(exp));
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return dot_clk_en_o;
            1: return char_clk_o;
            2: return serializer_load_o;
            default: return font_plane2_re_o;
        endcase
    endfunction

    // cycles between two consecutive pulses of a timing output
    task automatic per(input int s, input int e);
        int k;
        k = 0;
        do begin @(posedge clock_i); #1; k++; end while (!sig(s) && k < 300);
        k = 0;
        do begin @(posedge clock_i); #1; k++; end while (!sig(s) && k < 300);
        chk(16'(k), 16'(e));
    endtask

    task automatic settle();
        repeat (3) @(negedge clock_i);
    endtask

    task automatic give_verdict();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    logic [7:0] cfg [6] = '{8'h00, 8'h01, 8'h09, 8'h05, 8'h11, 8'h15};
    int         ech [6] = '{9, 8, 16, 8, 8, 8};
    int         eld [6] = '{9, 8, 16, 16, 32, 32};
    int         edt [6] = '{1, 1, 2, 1, 1, 1};
    logic [7:0] msk [4] = '{8'h3D, 8'h0F, 8'h3F, 8'h0E};
    logic [3:0] mm  [8] = '{4'h4, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h8};
    logic [3:0] wm  [8] = '{4'hF, 4'h5, 4'hF, 4'hF, 4'h3, 4'h3, 4'hF, 4'hB};
    logic [1:0] ad  [8] = '{2'h0, 2'h3, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2};
    logic [3:0] epw [8] = '{4'hF, 4'h5, 4'h5, 4'hA, 4'h1, 4'h2, 4'h4, 4'h0};

    initial begin
        repeat (10) @(negedge clock_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 6; i++) rd(3'(i), 8'h00);
        for (int i = 1; i < 6; i++) wr(3'(i), 8'hFF);
        ce_i = 1'b0;
        wr(3'h2, 8'h05); // frozen core drops this write
        ce_i = 1'b1;
        for (int i = 1; i < 5; i++) rd(3'(i), msk[i-1]);
        rd(3'h5, 8'h00);
        chk(16'(extended_memory_o), 16'h0001); // memory size bit from the FF write
        wr(3'h0, 8'h03);
        settle();
        chk(16'(running_o), 16'h0001);
        wr(3'h0, 8'h01);
        settle();
        chk(16'(running_o), 16'h0000);
        wr(3'h0, 8'h02);
        settle();
        chk(16'(running_o), 16'h0000);
        wr(3'h0, 8'h03);
        wr(3'h3, 8'h3F);
        wr(3'h0, 8'h01);
        rd(3'h3, 8'h3F);
        wr(3'h0, 8'h00);
        rd(3'h3, 8'h00);
        // timing changes only while halted; halts kept short
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, 8'h00);
            wr(3'h1, cfg[i]);
            wr(3'h0, 8'h03);
            per(0, edt[i]);
            per(1, ech[i]);
            per(2, eld[i]);
            per(3, ech[i]);
            chk(16'(interleave_o), cfg[i][4] ? 16'h0001 : 16'h0000);
        end
        // write enables in sequential, odd/even and quad chain modes, anded per plane with the write mask
        for (int i = 0; i < 8; i++) begin
            wr(3'h2, {4'h0, wm[i]});
            wr(3'h4, {4'h0, mm[i]});
            gfx_odd_even_i = (mm[i] == 4'h0);
            acc(1'b1, ad[i], 4'h1, epw[i]);
        end
        acc(1'b0, 2'h3, 4'h1, 4'h8);
        wr(3'h4, 8'h04);
        acc(1'b0, 2'h0, 4'h4, 4'h4);
        wr(3'h3, 8'h1A);
        char_code_i = 8'h41;
        char_row_i = 5'h03;
        @(negedge clock_i);
        row_start_i = 1'b1;
        @(negedge clock_i);
        row_start_i = 1'b0;
        settle();
        chk(font_addr_o, {3'h5, 8'h41, 5'h03});
        attr_bit3_i = 1'b1;
        settle();
        chk(font_addr_o, {3'h4, 8'h41, 5'h03});
        wr(3'h3, 8'h0F);
        attr_bit3_i = 1'b0;
        settle();
        chk(font_addr_o, {3'h5, 8'h41, 5'h03});
        row_start_i = 1'b1;
        @(negedge clock_i);
        row_start_i = 1'b0;
        attr_bit3_i = 1'b1;
        settle();
        chk(font_addr_o, {3'h6, 8'h41, 5'h03});
        wr(3'h1, 8'h21);
        settle();
        chk(16'(interleave_o), 16'h0002);
        chk(16'(video_black_o), 16'h0001);
        repeat (64) @(negedge clock_i);
        give_verdict();
    end

    // watchdog well past the expected several hundred cycles
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule

bind vsm_core vsm_chk chk_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .reg_index_i(reg_index_i), .reg_rdata_o(reg_rdata_o), .cpu_req_i(cpu_req_i),
    .cpu_we_i(cpu_we_i), .plane_we_o(plane_we_o), .char_code_i(char_code_i),
    .char_row_i(char_row_i), .font_addr_o(font_addr_o), .hsync_i(hsync_i),
    .vsync_i(vsync_i), .display_enable_flag_i(display_enable_flag_i),
    .running_o(running_o), .refresh_en_o(refresh_en_o), .mem_access_en_o(mem_access_en_o),
    .hsync_o(hsync_o), .vsync_o(vsync_o), .display_enable_flag_o(display_enable_flag_o),
    .video_black_o(video_black_o), .char_clk_o(char_clk_o), .interleave_o(interleave_o));
